// [common/tcr_pkg.sv]
// shared constants and carriers for the touch configuration register bank
package tcr_pkg;
   localparam int          REG_COUNT    = 22;
   localparam logic [7:0]  CMD_REG_READ  = 8'h20;
   localparam logic [7:0]  CMD_REG_WRITE = 8'h21;
   localparam logic [7:0]  STATUS_OK     = 8'h00;
   // register offsets
   localparam logic [7:0]  A_RISE_CAP_TMO   = 8'h00;
   localparam logic [7:0]  A_RISE_QUICK     = 8'h01;
   localparam logic [7:0]  A_TOUCH_THRESH   = 8'h02;
   localparam logic [7:0]  A_STABILITY      = 8'h03;
   localparam logic [7:0]  A_FAST_SAMPLE    = 8'h04;
   localparam logic [7:0]  A_SLOW_SAMPLE    = 8'h05;
   localparam logic [7:0]  A_FAST_POS       = 8'h06;
   localparam logic [7:0]  A_SLOW_POS       = 8'h07;
   localparam logic [7:0]  A_SPEED_LIMIT    = 8'h08;
   localparam logic [7:0]  A_DITHER         = 8'h09;
   localparam logic [7:0]  A_SLEEP          = 8'h0A;
   localparam logic [7:0]  A_LIFT_DEBOUNCE  = 8'h0B;
   localparam logic [7:0]  A_REPORT_ACTIONS = 8'h0C;
   localparam logic [7:0]  A_OPTIONS        = 8'h0D;
   localparam logic [7:0]  A_CAL_MARGIN     = 8'h0E;
   localparam logic [7:0]  A_SEQ_SPACING    = 8'h0F;
   localparam logic [7:0]  A_RESERVED       = 8'h10;
   localparam logic [7:0]  A_RATE_SPACING   = 8'h11;
   localparam logic [7:0]  A_RISE_BASE      = 8'h12;
   localparam logic [7:0]  A_RISE_OFFSET    = 8'h13;
   localparam logic [7:0]  A_STATE_FLAGS    = 8'h14;
   localparam logic [7:0]  A_DIAG_FLAGS     = 8'h15;
   localparam logic [7:0]  A_LAST           = 8'h15;
   // reset values, indexed by offset
   localparam logic [7:0] RESET_VALUE [REG_COUNT] = '{
      8'h18, 8'h02, 8'h80, 8'h04, 8'h04, 8'h08, 8'h08, 8'h08,
      8'h03, 8'h00, 8'h00, 8'h02, 8'hB1, 8'h89, 8'h40, 8'h04,
      8'h00, 8'h00, 8'h80, 8'h80, 8'h00, 8'h00};
   // field positions
   localparam int DOWN_MSB    = 7;
   localparam int DOWN_LSB    = 5;
   localparam int MOVE_MSB    = 4;
   localparam int MOVE_LSB    = 3;
   localparam int LIFT_MSB    = 2;
   localparam int LIFT_LSB    = 0;
   localparam int OPT_ENABLE  = 7;
   localparam int OPT_VERBOSE = 6;
   localparam int OPT_DYNAMIC = 3;
   localparam int OPT_WIRE    = 1;
   localparam int OPT_CAL     = 0;
   localparam int DBG_RISE    = 4;
   localparam int DBG_RISE_C  = 3;
   localparam int DBG_RISE_R  = 2;
   localparam logic [7:0] RISE_ZERO = 8'h80;
   // timing
   localparam int  CLK_NS          = 10;
   localparam int  RISE_STEP_US    = 10;
   localparam int  RISE_STEP_CYC   = RISE_STEP_US * 1000 / CLK_NS;
   localparam int  SLEEP_STEP_MS   = 250;
   localparam int  SLEEP_STEP_CYC  = SLEEP_STEP_MS * 1000000 / CLK_NS;
   localparam int  SPACING_STEP_US = 170;
   localparam int  SPACING_STEP_CYC = SPACING_STEP_US * 1000 / CLK_NS;

   typedef enum logic [1:0] {
      TCR_IDLE  = 2'b00,
      TCR_ADDR  = 2'b01,
      TCR_COUNT = 2'b10,
      TCR_DATA  = 2'b11
   } tcr_cmd_state_t;

   typedef enum logic [1:0] {
      TCR_SEQ_IDLE = 2'b00,
      TCR_SEQ_SEND = 2'b01,
      TCR_SEQ_WAIT = 2'b10
   } tcr_seq_state_t;

   // one measurement from the analog front end
   typedef struct packed {
      logic       valid;
      logic [7:0] touch_level;
      logic [7:0] stability;
      logic [7:0] raw_x;
      logic [7:0] raw_y;
      logic [11:0] pos_x;
      logic [11:0] pos_y;
   } tcr_meas_t;

   // one report toward the host
   typedef struct packed {
      logic        valid;
      logic        pen;
      logic [11:0] x;
      logic [11:0] y;
   } tcr_report_t;

   // ready-only state flags
   typedef struct packed {
      logic touch_check_result;
      logic stored_params_loaded;
      logic calibration_valid_flag;
      logic mode_jumper_state;
      logic risetime_cap_measured;
      logic eight_wire_configured;
      logic five_wire_configured;
      logic four_wire_configured;
   } tcr_flags_t;

   // rise-time adjustment in 10 us steps, signed around 128
   function automatic logic signed [8:0] tcr_rise_adjust(input logic [7:0] v);
      return $signed({1'b0, v}) - $signed({1'b0, RISE_ZERO});
   endfunction

   // absolute difference of two values
   function automatic logic [11:0] tcr_absdiff(input logic [11:0] a,
                                              input logic [11:0] b);
      return (a > b) ? a - b : b - a;
   endfunction
endpackage

// [design/tcr_bank.sv]
// touch controller configuration register bank with its consumers
`timescale 1ns/100ps
module tcr_bank
   import tcr_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // host command byte stream
   input  wire logic        cmd_valid,
   input  wire logic [7:0]  cmd_byte,
   input  wire logic        cmd_start,
   input  wire logic        serial_mode,
   // answer byte stream
   output logic             rsp_valid,
   output logic [7:0]       rsp_byte,
   // front end
   input  wire tcr_meas_t   meas,
   input  wire tcr_flags_t  state_flags,
   // derived settings
   output logic [7:0]       sample_count,
   output logic [3:0]       position_count,
   output logic signed [8:0] risetime_adjust,
   output logic [7:0]       calibration_inset_margin,
   output logic [7:0]       option_flags,
   output logic [7:0]       debug_flags,
   // touch results
   output logic             touch_detected,
   output logic             fast_motion,
   output tcr_report_t      report,
   output logic             sleep_now
);
   typedef struct packed {
      tcr_cmd_state_t cst;
      logic        is_write;
      logic [7:0]  ptr;
      logic [7:0]  left;
      logic        rsp_valid;
      logic [7:0]  rsp_byte;
      logic [7:0]  sample_count;
      logic [3:0]  position_count;
      logic signed [8:0] rise_adj;
      logic [7:0]  margin;
      logic        touch;
      logic        fast;
      logic        pen;
      logic [7:0]  lift_cnt;
      logic [11:0] rep_x;
      logic [11:0] rep_y;
      logic [7:0]  last_rx;
      logic [7:0]  last_ry;
      tcr_seq_state_t sst;
      logic [2:0]  seq;
      logic [1:0]  seq_idx;
      logic [19:0] tick;
      logic [7:0]  steps;
      tcr_report_t report;
      logic [31:0] idle_cyc;
      logic [7:0]  idle_steps;
      logic        sleep;
   } st_t;

   st_t        s;
   st_t        next_s;
   logic [7:0] regs [REG_COUNT];
   logic [7:0] next_regs [REG_COUNT];
   logic       rst_q;
   logic       rst_qq;

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_q  <= 1'b0;
         rst_qq <= 1'b0;
      end
      else
      begin
         rst_q  <= 1'b1;
         rst_qq <= rst_q;
      end
   end

   // pen-state bit of report n within the sequence for an action code
   function automatic logic seq_pen(input logic [2:0] code,
                                    input logic [1:0] n);
      unique case (code)
         3'd2:    return 1'b1;
         3'd3:    return (n == 2'd0);
         3'd4:    return (n == 2'd1);
         3'd5:    return (n == 2'd1);
         default: return 1'b0;
      endcase
   endfunction

   function automatic logic [1:0] seq_len(input logic [2:0] code);
      unique case (code)
         3'd1, 3'd2: return 2'd1;
         3'd3, 3'd5: return 2'd2;
         3'd4:       return 2'd3;
         default:    return 2'd0;
      endcase
   endfunction

   logic        moved;
   logic [11:0] dx;
   logic [11:0] dy;

   always_comb
   begin
      next_s    = s;
      next_regs = regs;
      next_s.rsp_valid = 1'b0;
      next_s.report.valid = 1'b0;
      moved = 1'b0;
      dx    = tcr_absdiff(meas.pos_x, s.rep_x);
      dy    = tcr_absdiff(meas.pos_y, s.rep_y);

      // command parsing after the command byte
      if (cmd_valid && cmd_start)
      begin
         // a command byte also ends a write burst and is never stored
         next_s.is_write = (cmd_byte == CMD_REG_WRITE);
         next_s.cst      = (cmd_byte == CMD_REG_READ || next_s.is_write) ?
                           TCR_ADDR : TCR_IDLE;
      end
      else if (cmd_valid)
      begin
         unique case (s.cst)
            TCR_IDLE: ;
            TCR_ADDR:
            begin
               next_s.ptr = cmd_byte;
               next_s.cst = s.is_write ? TCR_DATA : TCR_COUNT;
               if (s.is_write)
               begin
                  next_s.rsp_valid = 1'b1;
                  next_s.rsp_byte  = STATUS_OK;
               end
            end
            TCR_COUNT:
            begin
               next_s.left      = cmd_byte;
               next_s.rsp_valid = 1'b1;
               next_s.rsp_byte  = STATUS_OK;
               next_s.cst       = (cmd_byte == 8'h00) ? TCR_IDLE : TCR_DATA;
            end
            TCR_DATA:
               if (s.is_write)
               begin
                  if (s.ptr <= A_LAST && s.ptr != A_STATE_FLAGS &&
                      s.ptr != A_RESERVED)
                     next_regs[s.ptr[4:0]] = cmd_byte;
                  next_s.ptr = s.ptr + 8'h01;
               end
            default: next_s.cst = TCR_IDLE;
         endcase
      end
      if (s.cst == TCR_DATA && !s.is_write && !s.rsp_valid)
      begin
         next_s.rsp_valid = 1'b1;
         if (s.ptr == A_STATE_FLAGS)
            next_s.rsp_byte = state_flags;
         else if (s.ptr <= A_LAST)
            next_s.rsp_byte = regs[s.ptr[4:0]];
         else
            next_s.rsp_byte = 8'h00;
         next_s.ptr  = s.ptr + 8'h01;
         next_s.left = s.left - 8'h01;
         if (s.left == 8'h01)
            next_s.cst = TCR_IDLE;
      end

      next_s.rise_adj = tcr_rise_adjust(regs[A_RISE_OFFSET[4:0]]);
      next_s.margin = {1'b0, regs[A_CAL_MARGIN[4:0]][7:1]};

      if (meas.valid)
      begin
         next_s.touch = (meas.touch_level <= regs[A_TOUCH_THRESH[4:0]]) &&
                        (meas.stability <= regs[A_STABILITY[4:0]]);
         next_s.fast = (tcr_absdiff({4'h0, meas.raw_x}, {4'h0, s.last_rx})
                          > {4'h0, regs[A_SPEED_LIMIT[4:0]]}) ||
                       (tcr_absdiff({4'h0, meas.raw_y}, {4'h0, s.last_ry})
                          > {4'h0, regs[A_SPEED_LIMIT[4:0]]});
         next_s.last_rx = meas.raw_x;
         next_s.last_ry = meas.raw_y;
         moved = (dx > {4'h0, regs[A_DITHER[4:0]]}) ||
                 (dy > {4'h0, regs[A_DITHER[4:0]]});
      end
      next_s.sample_count = s.fast ? regs[A_FAST_SAMPLE[4:0]]
                                   : regs[A_SLOW_SAMPLE[4:0]];
      begin
         logic [7:0] pc;
         pc = s.fast ? regs[A_FAST_POS[4:0]] : regs[A_SLOW_POS[4:0]];
         if (pc == 8'h00)
            next_s.position_count = 4'd1;
         else if (pc > 8'h08)
            next_s.position_count = 4'd8;
         else
            next_s.position_count = pc[3:0];
      end

      // pen state and event dispatch
      if (meas.valid && s.sst == TCR_SEQ_IDLE)
      begin
         // only a fresh event starts a sequence, never a stale code
         next_s.seq = 3'd0;
         if (next_s.touch)
         begin
            next_s.lift_cnt = 8'h00;
            if (!s.pen)
            begin
               next_s.pen   = 1'b1;
               next_s.rep_x = meas.pos_x;
               next_s.rep_y = meas.pos_y;
               next_s.seq = regs[A_REPORT_ACTIONS[4:0]][DOWN_MSB:DOWN_LSB];
            end
            else if (moved)
            begin
               next_s.rep_x = meas.pos_x;
               next_s.rep_y = meas.pos_y;
               next_s.seq = {1'b0,
                  regs[A_REPORT_ACTIONS[4:0]][MOVE_MSB:MOVE_LSB]};
            end
         end
         else if (s.pen)
         begin
            if (s.lift_cnt >= regs[A_LIFT_DEBOUNCE[4:0]])
            begin
               next_s.pen = 1'b0;
               next_s.seq = regs[A_REPORT_ACTIONS[4:0]][LIFT_MSB:LIFT_LSB];
            end
            else
               next_s.lift_cnt = s.lift_cnt + 8'h01;
         end
         if (seq_len(next_s.seq) != 2'd0 &&
             regs[A_OPTIONS[4:0]][OPT_ENABLE])
         begin
            next_s.sst     = TCR_SEQ_SEND;
            next_s.seq_idx = 2'd0;
         end
      end

      unique case (s.sst)
         TCR_SEQ_IDLE: ;
         TCR_SEQ_SEND:
         begin
            next_s.report.valid = 1'b1;
            next_s.report.pen   = seq_pen(s.seq, s.seq_idx);
            next_s.report.x     = s.rep_x;
            next_s.report.y     = s.rep_y;
            next_s.seq_idx      = s.seq_idx + 2'd1;
            next_s.tick         = 20'd0;
            next_s.steps        = 8'h00;
            next_s.sst = (s.seq_idx + 2'd1 >= seq_len(s.seq)) ?
                         TCR_SEQ_IDLE : TCR_SEQ_WAIT;
         end
         TCR_SEQ_WAIT:
         begin
            if (s.steps >= regs[A_SEQ_SPACING[4:0]])
               next_s.sst = TCR_SEQ_SEND;
            else if (s.tick == 20'(SPACING_STEP_CYC - 1))
            begin
               next_s.tick  = 20'd0;
               next_s.steps = s.steps + 8'h01;
            end
            else
               next_s.tick = s.tick + 20'd1;
         end
         default: next_s.sst = TCR_SEQ_IDLE;
      endcase

      // sleep only in serial mode after idle
      if (!serial_mode || cmd_valid || s.touch ||
          regs[A_SLEEP[4:0]] == 8'h00)
      begin
         next_s.idle_cyc   = 32'd0;
         next_s.idle_steps = 8'h00;
         next_s.sleep      = 1'b0;
      end
      else if (s.idle_steps >= regs[A_SLEEP[4:0]])
         next_s.sleep = 1'b1;
      else if (s.idle_cyc == 32'(SLEEP_STEP_CYC - 1))
      begin
         next_s.idle_cyc   = 32'd0;
         next_s.idle_steps = s.idle_steps + 8'h01;
      end
      else
         next_s.idle_cyc = s.idle_cyc + 32'd1;
   end

   always_ff @(posedge clk or negedge rst_qq)
   begin
      if (!rst_qq)
      begin
         s <= '0;
         for (int i = 0; i < REG_COUNT; i++)
            regs[i] <= RESET_VALUE[i];
      end
      else
      begin
         s    <= next_s;
         regs <= next_regs;
      end
   end

   assign rsp_valid       = s.rsp_valid;
   assign rsp_byte        = s.rsp_byte;
   assign sample_count    = s.sample_count;
   assign position_count  = s.position_count;
   assign risetime_adjust = s.rise_adj;
   assign calibration_inset_margin = s.margin;
   assign option_flags    = regs[A_OPTIONS[4:0]];
   assign debug_flags     = regs[A_DIAG_FLAGS[4:0]];
   assign touch_detected  = s.touch;
   assign fast_motion     = s.fast;
   assign report          = s.report;
   assign sleep_now       = s.sleep;
endmodule

// [tb/tcr_bank_properties.sv]
// concurrent checks on the register bank ports
`timescale 1ns/100ps
module tcr_bank_properties
   import tcr_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              nrst,
   // host command stream
   input  wire logic              cmd_valid,
   input  wire logic [7:0]        cmd_byte,
   input  wire logic              cmd_start,
   input  wire logic              serial_mode,
   // answers and settings
   input  wire logic              rsp_valid,
   input  wire logic [7:0]        rsp_byte,
   input  wire logic [3:0]        position_count,
   input  wire logic signed [8:0] risetime_adjust,
   input  wire logic [7:0]        option_flags,
   input  wire logic              sleep_now
);
   logic [2:0] up;

   // internal reset lags the pin, so skip the first edges
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         up <= 3'h0;
      else if (up != 3'h7)
         up <= up + 3'h1;
   end

   default clocking @(posedge clk);
   endclocking
   default disable iff (!nrst);

   sequence read_head;
      cmd_valid && cmd_start && cmd_byte == CMD_REG_READ
      ##1 cmd_valid && !cmd_start
      ##1 cmd_valid && !cmd_start && cmd_byte != 8'h00;
   endsequence
   sequence write_head;
      cmd_valid && cmd_start && cmd_byte == CMD_REG_WRITE
      ##1 cmd_valid && !cmd_start;
   endsequence
   sequence status_byte;
      rsp_valid && rsp_byte == STATUS_OK;
   endsequence

   chk_read_status: assert property (read_head |=> status_byte)
      else $error("read status byte missing");
   chk_read_first: assert property (read_head ##1 status_byte |-> ##2 rsp_valid)
      else $error("first read value not two cycles after status");
   chk_write_ack: assert property (write_head |=> status_byte)
      else $error("write acknowledge missing");
   chk_rsp_single: assert property (rsp_valid |=> !rsp_valid)
      else $error("answer strobe longer than one cycle");
   chk_opt_quiet: assert property (up == 3'h7 && $changed(option_flags) |->
      $past(cmd_valid) || $past(cmd_valid, 2) || $past(cmd_valid, 3))
      else $error("option flags changed without host traffic");
   chk_rt_quiet: assert property (up == 3'h7 && !cmd_valid
      && !$past(cmd_valid) && !$past(cmd_valid, 2) |=> $stable(risetime_adjust))
      else $error("rise-time adjust changed without host traffic");
   chk_pos_range: assert property (up == 3'h7 |->
      position_count >= 4'h1 && position_count <= 4'h8)
      else $error("position count out of range");
   chk_sleep_serial: assert property (up == 3'h7 && !serial_mode
      && !$past(serial_mode) |-> !sleep_now)
      else $error("sleep outside serial mode");
endmodule

bind tcr_bank tcr_bank_properties u_chk (.clk(clk), .nrst(nrst),
   .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_start(cmd_start),
   .serial_mode(serial_mode), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte),
   .position_count(position_count), .risetime_adjust(risetime_adjust),
   .option_flags(option_flags), .sleep_now(sleep_now));

// [tb/tcr_host_model.sv]
// host model issuing register commands and gathering answers
`timescale 1ns/100ps
module tcr_host_model
   import tcr_pkg::*;
(
   // clock
   input  wire logic       clk,
   // command stream toward the bank
   output logic            cmd_valid,
   output logic [7:0]      cmd_byte,
   output logic            cmd_start,
   // answer stream from the bank
   input  wire logic       rsp_valid,
   input  wire logic [7:0] rsp_byte
);
   logic [7:0] rxq [$];

   initial
   begin
      cmd_valid = 1'b0;
      cmd_byte  = 8'h00;
      cmd_start = 1'b0;
   end

   always @(posedge clk)
   begin
      if (rsp_valid === 1'b1)
         rxq.push_back(rsp_byte);
   end

   task automatic send(input logic [7:0] b, input logic s);
      cmd_valid <= 1'b1;
      cmd_byte  <= b;
      cmd_start <= s;
      @(posedge clk);
   endtask

   // released byte lane toggles so stale data is never mistaken
   task automatic idle(input int n);
      cmd_valid <= 1'b0;
      cmd_start <= 1'b0;
      cmd_byte  <= ~cmd_byte;
      repeat (n) @(posedge clk);
   endtask

   // command, start address, then values in address order
   task automatic reg_write(input logic [7:0] a, input logic [7:0] v [$]);
      send(CMD_REG_WRITE, 1'b1);
      send(a, 1'b0);
      foreach (v[i])
         send(v[i], 1'b0);
      idle(4);
   endtask

   task automatic reg_read(input logic [7:0] a, input logic [7:0] n);
      send(CMD_REG_READ, 1'b1);
      send(a, 1'b0);
      send(n, 1'b0);
      idle(2 * n + 6);
   endtask
endmodule

// [tb/test_tcr_bank.sv]
// self-checking bench for the touch configuration register bank
`timescale 1ns/100ps
module test_tcr_bank;
   import tcr_pkg::*;
   logic              clk;
   logic              nrst;
   logic              serial_mode;
   logic              cmd_valid;
   logic              cmd_start;
   logic [7:0]        cmd_byte;
   logic              rsp_valid;
   logic [7:0]        rsp_byte;
   tcr_meas_t         meas;
   tcr_flags_t        state_flags;
   logic [7:0]        sample_count;
   logic [3:0]        position_count;
   logic signed [8:0] risetime_adjust;
   logic [7:0]        cal_margin;
   logic [7:0]        option_flags;
   logic [7:0]        debug_flags;
   logic              touch_detected;
   logic              fast_motion;
   tcr_report_t       report;
   logic              sleep_now;
   int                mismatches;
   int                num_checks;
   int                model [22];
   logic [7:0]        wq [$];
   logic [12:0]       rq [$];

   tcr_bank uut (.clk(clk), .nrst(nrst), .cmd_valid(cmd_valid),
      .cmd_byte(cmd_byte), .cmd_start(cmd_start), .serial_mode(serial_mode),
      .rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .meas(meas),
      .state_flags(state_flags), .sample_count(sample_count),
      .position_count(position_count), .risetime_adjust(risetime_adjust),
      .calibration_inset_margin(cal_margin), .option_flags(option_flags),
      .debug_flags(debug_flags), .touch_detected(touch_detected),
      .fast_motion(fast_motion), .report(report), .sleep_now(sleep_now));
   tcr_host_model host (.clk(clk), .cmd_valid(cmd_valid),
      .cmd_byte(cmd_byte), .cmd_start(cmd_start), .rsp_valid(rsp_valid),
      .rsp_byte(rsp_byte));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic check_out(input logic [8:0] got, input logic [8:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_rsp(input logic [7:0] exp);
      logic [7:0] got;
      got = 8'hXX;
      if (host.rxq.size() > 0)
         got = host.rxq.pop_front();
      check_out({1'b0, got}, {1'b0, exp});
   endtask

   // every report pulse kept as pen state over x position
   always @(posedge clk)
   begin
      if (report.valid === 1'b1)
         rq.push_back({report.pen, report.x});
   end

   task automatic check_rep(input logic [12:0] exp);
      logic [12:0] got;
      got = 'x;
      if (rq.size() > 0)
         got = rq.pop_front();
      num_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic logic [7:0] expect_at(input int a);
      if (a > 21)
         return 8'h00;
      if (a == 20)
         return state_flags;
      return model[a][7:0];
   endfunction

   // zero reads as one, above eight as eight
   function automatic logic [8:0] pos_exp(input int v);
      return (v == 0) ? 9'h001 : (v > 8) ? 9'h008 : 9'(v);
   endfunction

   task automatic read_check(input int a, input int n);
      host.reg_read(a[7:0], n[7:0]);
      check_rsp(STATUS_OK);
      for (int i = 0; i < n; i++)
         check_rsp(expect_at(a + i));
   endtask

   task automatic write_check(input int a);
      host.reg_write(a[7:0], wq);
      check_rsp(STATUS_OK);
      foreach (wq[i])
         if (a + i != 16 && a + i != 20 && a + i < 22)
            model[a + i] = wq[i];
   endtask

   task automatic measure(input logic [7:0] lvl, input logic [7:0] stb,
                          input logic [7:0] rx);
      meas.valid       <= 1'b1;
      meas.touch_level <= lvl;
      meas.stability   <= stb;
      meas.raw_x       <= rx;
      meas.raw_y       <= rx;
      meas.pos_x       <= {rx, 4'h0};
      meas.pos_y       <= {rx, 4'h0};
      @(posedge clk);
      meas.valid <= 1'b0;
      repeat (4) @(posedge clk);
   endtask

   initial
   begin
      #500000;
      mismatches++;
      report_and_stop();
   end

   initial
   begin
      mismatches = 0;
      num_checks = 0;
      nrst = 1'b0;
      serial_mode = 1'b1;
      meas = '0;
      state_flags = '0;
      model = '{8'h18, 8'h02, 8'h80, 8'h04, 8'h04, 8'h08, 8'h08, 8'h08,
                8'h03, 8'h00, 8'h00, 8'h02, 8'hB1, 8'h89, 8'h40, 8'h04,
                8'h00, 8'h00, 8'h80, 8'h80, 8'h00, 8'h00};
      void'($urandom(19221));
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      repeat (5) @(posedge clk);
      state_flags <= 8'($urandom());
      read_check(0, 22);
      $display("test defaults done");
      for (int i = 0; i < 22; i++)
         wq.push_back(8'($urandom()));
      wq[0] = 8'h18;
      wq[1] = 8'h02;
      write_check(0);
      wq = '{8'h50, 8'h06};
      write_check(2);
      wq = '{8'h03};
      write_check(8);
      state_flags <= 8'($urandom());
      read_check(0, 22);
      read_check(22, 2);
      $display("test write and read back done");
      check_out(risetime_adjust, 9'(model[19] - 128));
      check_out({1'b0, cal_margin}, 9'(model[14] / 2));
      check_out({1'b0, option_flags}, 9'(model[13]));
      check_out({1'b0, debug_flags}, 9'(model[21]));
      measure(8'h50, 8'h06, 8'h20);
      measure(8'h50, 8'h06, 8'h20);
      check_out({8'h00, fast_motion}, 9'h000);
      check_out({1'b0, sample_count}, 9'(model[5]));
      check_out({5'h00, position_count}, pos_exp(model[7]));
      check_out({8'h00, touch_detected}, 9'h001);
      measure(8'h50, 8'h06, 8'h60);
      check_out({8'h00, fast_motion}, 9'h001);
      check_out({1'b0, sample_count}, 9'(model[4]));
      check_out({5'h00, position_count}, pos_exp(model[6]));
      measure(8'h51, 8'h06, 8'h60);
      check_out({8'h00, touch_detected}, 9'h000);
      measure(8'h50, 8'h07, 8'h60);
      check_out({8'h00, touch_detected}, 9'h000);
      measure(8'h4F, 8'h05, 8'h60);
      check_out({8'h00, touch_detected}, 9'h001);
      serial_mode <= 1'b0;
      repeat (4) @(posedge clk);
      check_out({8'h00, sleep_now}, 9'h000);
      $display("test derived settings done");
      // lift debounce 1, down 4, move 2, up 3, enabled, no spacing
      wq = '{8'h01, 8'h93, 8'h80, 8'h40, 8'h00};
      write_check(11);
      // lift the pen and drain whatever ran before
      repeat (3) measure(8'hFF, 8'h00, 8'h30);
      repeat (4) @(posedge clk);
      rq.delete();
      measure(8'h10, 8'h00, 8'h30);
      repeat (4) @(posedge clk);
      measure(8'h10, 8'h00, 8'h30);
      measure(8'h10, 8'h00, 8'h40);
      measure(8'hFF, 8'h00, 8'h40);
      measure(8'h10, 8'h00, 8'h40);
      measure(8'hFF, 8'h00, 8'h40);
      check_out(9'(rq.size()), 9'h004);
      measure(8'hFF, 8'h00, 8'h40);
      repeat (4) @(posedge clk);
      check_rep(13'h0300);
      check_rep(13'h1300);
      check_rep(13'h0300);
      check_rep(13'h1400);
      check_rep(13'h1400);
      check_rep(13'h0400);
      check_out(9'(rq.size()), 9'h000);
      $display("test report sequences done");
      report_and_stop();
   end
endmodule
